// [verilog/hpm_top.sv]
// Purpose: Routes the shared host pads to SDIO or to SPI plus UART, and
//          handles hard reset, wake from doze, the host interrupt and I2C.
// Assumes: LINK_CLK is the host bus clock that the link engines run on.
// Notes:   The mode is caught while the device is held in hard reset.
// Notes on behaviour
// - While the hard reset pin is low the device stays in reset and does nothing.
// - Once the hard reset pin is high the device leaves reset and runs normally.
// - A high strap routes the shared host pads to the SPI port.
// - A low strap routes the shared host pads to the SDIO port.
// - The device leaves doze when the host drives the wake input high.
// - Pad d3 is SDIO data 3 in SDIO mode and the UART transmit output in SPI mode.
// - Pad d2 is SDIO data 2 in SDIO mode and the MOSI input in SPI mode.
// - Pad d1 is SDIO data 1 in SDIO mode and the active-low select input in SPI mode.
// - Pad d0 is SDIO data 0 in SDIO mode and the MISO output in SPI mode.
// - The command pad is the SDIO command line or the SPI clock input.
// - The clock pad is the SDIO clock input or the UART receive input.
// - The test-only I2C port can be set to act as bus master or as bus slave.
`timescale 1ns/1ps
module hpm_top (
  input  wire logic       CLK,                     // System clock, 40 MHz.
  input  wire logic       SYS_RST,                 // Asynchronous reset, high.
  input  wire logic       LINK_CLK,                // Host bus clock.
  input  wire logic       HARD_RST_N,              // Hard reset pin, low.
  input  wire logic       STRAP_SPI,               // Interface-select strap pin.
  input  wire logic       HOST_WAKE,               // Wake pin from host.
  input  wire logic       DOZE_REQ,                // Core asks to enter doze.
  input  wire logic       IRQ_PENDING,             // Core has pending events.
  input  wire logic       UART_TX_OUT,             // Core UART transmit bit.
  input  wire logic       SDIO_CMD_OUT,            // Link command out bit.
  input  wire logic       SDIO_CMD_DRV,            // Link command drive.
  input  wire logic [3:0] SDIO_DAT_OUT,            // Link data out bits.
  input  wire logic [3:0] SDIO_DAT_DRV,            // Link data drives.
  input  wire logic       SPI_MISO_OUT,            // Link MISO bit.
  input  wire logic       SPI_MISO_DRV,            // Link MISO drive.
  input  wire logic       I2C_MASTER_SEL,          // I2C acts as master.
  input  wire logic       I2C_SCL_PULL,            // Core pulls SCL low.
  input  wire logic       I2C_SDA_PULL,            // Core pulls SDA low.
  output logic            CORE_RUN,                // Device out of reset.
  output logic            DOZE_ACTIVE,             // Device is dozing.
  output logic            WAKE_EVENT,              // Doze left, one cycle.
  output logic            SPI_MODE,                // Latched mode.
  output logic            HOST_INTERRUPT_LOW,      // Interrupt to host, low.
  output logic            SDIO_CLK_IN,             // Routed SDIO clock.
  output logic            SDIO_CMD_IN,             // Routed SDIO command.
  output logic [3:0]      SDIO_DAT_IN,             // Routed SDIO data.
  output logic            SPI_SCLK_IN,             // Routed SPI clock.
  output logic            SPI_MOSI_IN,             // Routed MOSI.
  output logic            SPI_SEL_N_IN,            // Routed select, low.
  output logic            UART_RX_IN,              // Routed UART receive.
  output logic            I2C_SCL_IN,              // Synced SCL level.
  output logic            I2C_SDA_IN,              // Synced SDA level.
  input  wire logic       PAD_D3_OR_SERIAL_TX_I,   // Pad d3 input.
  output logic            PAD_D3_OR_SERIAL_TX_O,   // Pad d3 output.
  output logic            PAD_D3_OR_SERIAL_TX_OE,  // Pad d3 drive.
  input  wire logic       PAD_D2_OR_MOSI_I,        // Pad d2 input.
  output logic            PAD_D2_OR_MOSI_O,        // Pad d2 output.
  output logic            PAD_D2_OR_MOSI_OE,       // Pad d2 drive.
  input  wire logic       PAD_D1_OR_SELECT_I,      // Pad d1 input.
  output logic            PAD_D1_OR_SELECT_O,      // Pad d1 output.
  output logic            PAD_D1_OR_SELECT_OE,     // Pad d1 drive.
  input  wire logic       PAD_D0_OR_MISO_I,        // Pad d0 input.
  output logic            PAD_D0_OR_MISO_O,        // Pad d0 output.
  output logic            PAD_D0_OR_MISO_OE,       // Pad d0 drive.
  input  wire logic       PAD_CMD_OR_SCLK_I,       // Command pad input.
  output logic            PAD_CMD_OR_SCLK_O,       // Command pad output.
  output logic            PAD_CMD_OR_SCLK_OE,      // Command pad drive.
  input  wire logic       PAD_CLK_OR_SERIAL_RX_I,  // Clock pad input.
  output logic            PAD_CLK_OR_SERIAL_RX_O,  // Clock pad output.
  output logic            PAD_CLK_OR_SERIAL_RX_OE, // Clock pad drive.
  input  wire logic       I2C_SCL_I,               // SCL pad input.
  output logic            I2C_SCL_O,               // SCL pad output.
  output logic            I2C_SCL_OE,              // SCL pad drive.
  input  wire logic       I2C_SDA_I,               // SDA pad input.
  output logic            I2C_SDA_O,               // SDA pad output.
  output logic            I2C_SDA_OE               // SDA pad drive.
);

  // System domain state.
  logic [4:0]         sync1_reg;
  logic [4:0]         sync2_reg;
  logic [4:0]         pins_raw;
  hpm_pkg::hpm_state_t state_reg;
  hpm_pkg::hpm_state_t state_next;
  logic               mode_reg;
  logic               mode_next;
  logic               run_reg;
  logic               run_next;
  logic               doze_reg;
  logic               wake_ev_reg;
  logic               wake_ev_next;
  logic               irq_n_reg;
  logic               irq_n_next;
  logic               uart_tx_reg;
  logic               scl_oe_reg;
  logic               sda_oe_reg;
  logic               hrst_s;
  logic               strap_s;
  logic               wake_s;
  // Link domain state.
  logic               mode_l1_reg;
  logic               mode_l2_reg;
  logic               run_l1_reg;
  logic               run_l2_reg;
  logic               cmd_o_reg;
  logic               cmd_oe_reg;
  logic [3:0]         dat_o_reg;
  logic [3:0]         dat_oe_reg;
  logic               miso_o_reg;
  logic               miso_oe_reg;
  logic               sdio_on_l;
  logic               spi_on_l;
  // Pad vectors for the shared data lanes.
  logic [3:0]         pad_i;
  logic [3:0]         pad_o;
  logic [3:0]         pad_oe;
  logic [3:0]         spi_o_vec;
  logic [3:0]         spi_oe_vec;
  logic [3:0]         spi_in_lane;
  logic               is_spi;
  logic               is_sdio;

  // The reset, strap, wake and I2C pin levels pass two flops; only the second stage is read.
  assign pins_raw = {I2C_SDA_I, I2C_SCL_I, HOST_WAKE, STRAP_SPI, HARD_RST_N};
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      sync1_reg <= 5'h00;
      sync2_reg <= 5'h00;
    end else begin
      sync1_reg <= pins_raw;
      sync2_reg <= sync1_reg;
    end
  end

  // Named views of the synchronised pins.
  assign hrst_s     = sync2_reg[0];
  assign strap_s    = sync2_reg[1];
  assign wake_s     = sync2_reg[2];
  assign I2C_SCL_IN = sync2_reg[3];
  assign I2C_SDA_IN = sync2_reg[4];

  // Control state; a low hard reset pin overrides everything else.
  always_comb begin
    state_next = state_reg;
    if (!hrst_s) begin
      state_next = hpm_pkg::ST_RESET;
    end else begin
      case (state_reg)
        hpm_pkg::ST_RESET: begin
          state_next = hpm_pkg::ST_RUN;
        end
        hpm_pkg::ST_RUN: begin
          if (DOZE_REQ && !wake_s) begin
            state_next = hpm_pkg::ST_DOZE;
          end
        end
        hpm_pkg::ST_DOZE: begin
          if (wake_s) begin
            state_next = hpm_pkg::ST_RUN;
          end
        end
        default: begin
          state_next = hpm_pkg::ST_RESET;
        end
      endcase
    end
  end

  // The strap is caught on every cycle spent in reset and frozen after, so a
  // strap that moves during operation cannot swap the pads under the host.
  // strap high SPI
  assign mode_next = (state_reg == hpm_pkg::ST_RESET) ? strap_s : mode_reg;
  assign run_next  = (state_next != hpm_pkg::ST_RESET);
  assign wake_ev_next = (state_reg == hpm_pkg::ST_DOZE) &&
                        (state_next == hpm_pkg::ST_RUN);
  assign irq_n_next = !(IRQ_PENDING && run_next);

  // System domain registers.
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_reg   <= hpm_pkg::ST_RESET;
      mode_reg    <= hpm_pkg::MODE_SDIO;
      run_reg     <= hpm_pkg::RST_LOW;
      doze_reg    <= hpm_pkg::RST_LOW;
      wake_ev_reg <= hpm_pkg::RST_LOW;
      irq_n_reg   <= hpm_pkg::RST_IRQ_N;
    end else begin
      state_reg   <= state_next;
      mode_reg    <= mode_next;
      run_reg     <= run_next;
      doze_reg    <= (state_next == hpm_pkg::ST_DOZE);
      wake_ev_reg <= wake_ev_next;
      irq_n_reg   <= irq_n_next;
    end
  end

  // UART transmit and I2C drives belong to the system domain.
  // master or slave
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      uart_tx_reg <= hpm_pkg::RST_UART_TX;
      scl_oe_reg  <= hpm_pkg::RST_LOW;
      sda_oe_reg  <= hpm_pkg::RST_LOW;
    end else begin
      uart_tx_reg <= UART_TX_OUT || !run_next;
      scl_oe_reg  <= run_next && I2C_MASTER_SEL && I2C_SCL_PULL;
      sda_oe_reg  <= run_next && I2C_SDA_PULL;
    end
  end

  // Mode and run levels cross into the link domain through two flops.
  always_ff @(posedge LINK_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      mode_l1_reg <= hpm_pkg::MODE_SDIO;
      mode_l2_reg <= hpm_pkg::MODE_SDIO;
      run_l1_reg  <= hpm_pkg::RST_LOW;
      run_l2_reg  <= hpm_pkg::RST_LOW;
    end else begin
      mode_l1_reg <= mode_reg;
      mode_l2_reg <= mode_l1_reg;
      run_l1_reg  <= run_reg;
      run_l2_reg  <= run_l1_reg;
    end
  end

  // Link-side drive enables per interface.
  assign sdio_on_l = run_l2_reg && (mode_l2_reg == hpm_pkg::MODE_SDIO);
  assign spi_on_l  = run_l2_reg && (mode_l2_reg == hpm_pkg::MODE_SPI);

  // Pad output flops on the host clock; the host clock may stop, so the
  // final enables are also gated by the system-domain run flag below.
  always_ff @(posedge LINK_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cmd_o_reg   <= hpm_pkg::RST_LOW;
      cmd_oe_reg  <= hpm_pkg::RST_LOW;
      dat_o_reg   <= hpm_pkg::RST_NIBBLE;
      dat_oe_reg  <= hpm_pkg::RST_NIBBLE;
      miso_o_reg  <= hpm_pkg::RST_LOW;
      miso_oe_reg <= hpm_pkg::RST_LOW;
    end else begin
      cmd_o_reg   <= SDIO_CMD_OUT;
      cmd_oe_reg  <= sdio_on_l && SDIO_CMD_DRV;
      dat_o_reg   <= SDIO_DAT_OUT;
      dat_oe_reg  <= sdio_on_l ? SDIO_DAT_DRV : hpm_pkg::RST_NIBBLE;
      miso_o_reg  <= SPI_MISO_OUT;
      miso_oe_reg <= spi_on_l && SPI_MISO_DRV;
    end
  end

  // Mode decode; the mode is stable whenever run is high.
  assign is_spi  = run_reg && (mode_reg == hpm_pkg::MODE_SPI);
  assign is_sdio = run_reg && (mode_reg == hpm_pkg::MODE_SDIO);

  // SPI-mode roles of the data lanes: d3 UART out, d2 and d1 inputs, d0 MISO.
  // d3 serial tx
  assign spi_o_vec  = {uart_tx_reg, hpm_pkg::IDLE_LOW, hpm_pkg::IDLE_LOW, miso_o_reg};
  assign spi_oe_vec = {1'h1, hpm_pkg::IDLE_LOW, hpm_pkg::IDLE_LOW, miso_oe_reg};
  assign pad_i = {PAD_D3_OR_SERIAL_TX_I, PAD_D2_OR_MOSI_I,
                  PAD_D1_OR_SELECT_I, PAD_D0_OR_MISO_I};

  // One mux per data lane; in SDIO mode every lane is a plain data line.
  genvar lane;
  generate
    for (lane = 0; lane < hpm_pkg::DATA_PADS; lane = lane + 1) begin : g_lane
      assign pad_o[lane]  = is_spi ? spi_o_vec[lane] : dat_o_reg[lane];
      assign pad_oe[lane] = is_spi ? spi_oe_vec[lane] : (is_sdio && dat_oe_reg[lane]);
      assign SDIO_DAT_IN[lane] = is_sdio ? pad_i[lane] : hpm_pkg::IDLE_LOW;
      assign spi_in_lane[lane] = is_spi && pad_i[lane];
    end
  endgenerate

  // Data pad outputs.
  assign PAD_D3_OR_SERIAL_TX_O  = pad_o[3];
  assign PAD_D3_OR_SERIAL_TX_OE = pad_oe[3];
  assign PAD_D2_OR_MOSI_O       = pad_o[2];
  assign PAD_D2_OR_MOSI_OE      = pad_oe[2];
  assign PAD_D1_OR_SELECT_O     = pad_o[1];
  assign PAD_D1_OR_SELECT_OE    = pad_oe[1];
  assign PAD_D0_OR_MISO_O       = pad_o[0];
  assign PAD_D0_OR_MISO_OE      = pad_oe[0];

  // Command and clock pads; the clock pad is an input in both modes.
  // cmd or sclk
  assign PAD_CMD_OR_SCLK_O       = cmd_o_reg;
  assign PAD_CMD_OR_SCLK_OE      = is_sdio && cmd_oe_reg;
  assign PAD_CLK_OR_SERIAL_RX_O  = hpm_pkg::IDLE_LOW;
  assign PAD_CLK_OR_SERIAL_RX_OE = hpm_pkg::IDLE_LOW;
  assign SDIO_CMD_IN  = is_sdio && PAD_CMD_OR_SCLK_I;
  assign SDIO_CLK_IN  = is_sdio && PAD_CLK_OR_SERIAL_RX_I;
  assign SPI_SCLK_IN  = is_spi && PAD_CMD_OR_SCLK_I;
  assign SPI_MOSI_IN  = spi_in_lane[2];
  // Unused inputs idle high so the core sees no select and a quiet line.
  assign SPI_SEL_N_IN = is_spi ? PAD_D1_OR_SELECT_I : hpm_pkg::IDLE_SEL_N;
  assign UART_RX_IN   = is_spi ? PAD_CLK_OR_SERIAL_RX_I : hpm_pkg::IDLE_UART;

  // I2C pads are open drain: they only ever pull low.
  assign I2C_SCL_O  = hpm_pkg::IDLE_LOW;
  assign I2C_SCL_OE = scl_oe_reg;
  assign I2C_SDA_O  = hpm_pkg::IDLE_LOW;
  assign I2C_SDA_OE = sda_oe_reg;

  // Status outputs to the core.
  assign CORE_RUN           = run_reg;
  assign DOZE_ACTIVE        = doze_reg;
  assign WAKE_EVENT         = wake_ev_reg;
  assign SPI_MODE           = mode_reg;
  assign HOST_INTERRUPT_LOW = irq_n_reg;

  // Checks on the behaviour above.
  reset_hold_a: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    !hrst_s |=> (state_reg == hpm_pkg::ST_RESET) && !CORE_RUN && !pad_oe[3]
  ) else $error("Device active while hard reset is low.");

  reset_exit_a: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    (state_reg == hpm_pkg::ST_RESET) && hrst_s |=> CORE_RUN && !DOZE_ACTIVE
  ) else $error("Device did not leave reset.");

  strap_latch_a: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    (state_reg == hpm_pkg::ST_RESET) ##1 CORE_RUN |-> SPI_MODE == $past(strap_s)
  ) else $error("Mode does not match strap.");

  spi_route_a: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    CORE_RUN && SPI_MODE |-> SPI_SEL_N_IN == PAD_D1_OR_SELECT_I &&
      UART_RX_IN == PAD_CLK_OR_SERIAL_RX_I && !SDIO_CMD_IN
  ) else $error("SPI routing wrong.");

  sdio_route_a: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    CORE_RUN && !SPI_MODE |-> SDIO_CLK_IN == PAD_CLK_OR_SERIAL_RX_I &&
      SDIO_DAT_IN[2] == PAD_D2_OR_MOSI_I && SPI_SEL_N_IN
  ) else $error("SDIO routing wrong.");

  wake_exit_a: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    (state_reg == hpm_pkg::ST_DOZE) && wake_s && hrst_s |=>
      WAKE_EVENT && !DOZE_ACTIVE ##1 !WAKE_EVENT
  ) else $error("Wake did not end doze.");

  tx_drive_a: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    CORE_RUN && SPI_MODE |-> PAD_D3_OR_SERIAL_TX_OE &&
      PAD_D3_OR_SERIAL_TX_O == uart_tx_reg
  ) else $error("UART transmit not on pad d3.");

  spi_inputs_a: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    SPI_MODE |-> !PAD_D2_OR_MOSI_OE && !PAD_D1_OR_SELECT_OE
  ) else $error("SPI input pad driven.");

  miso_out_a: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    CORE_RUN && SPI_MODE |-> PAD_D0_OR_MISO_O == miso_o_reg &&
      PAD_D0_OR_MISO_OE == miso_oe_reg
  ) else $error("MISO not on pad d0.");

  clock_pads_a: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    SPI_MODE |-> !PAD_CMD_OR_SCLK_OE && !PAD_CLK_OR_SERIAL_RX_OE
  ) else $error("Clock pad driven in SPI mode.");

  link_cmd_a: assert property (
    @(posedge LINK_CLK) disable iff (SYS_RST)
    mode_l2_reg |=> !cmd_oe_reg
  ) else $error("Command drive in SPI mode.");

  i2c_slave_a: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    !I2C_MASTER_SEL |=> !I2C_SCL_OE
  ) else $error("Slave drives SCL.");

  irq_level_a: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    IRQ_PENDING && hrst_s && (state_reg != hpm_pkg::ST_RESET) |=> !HOST_INTERRUPT_LOW
  ) else $error("Interrupt not asserted.");

  irq_free_a: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    !IRQ_PENDING |=> HOST_INTERRUPT_LOW
  ) else $error("Interrupt not released.");

endmodule : hpm_top

// [verilog/hpm_pkg.sv]
// Purpose: Shared constants for the host port pin mux.
// Assumes: One system clock and one host link clock.
// Notes:   Mode codes follow the level of the interface-select strap.
package hpm_pkg;

  // Interface mode, equal to the strap level that selects it.
  localparam logic MODE_SDIO = 1'h0;
  localparam logic MODE_SPI  = 1'h1;

  // Idle levels seen by the core on inputs of the unused interface.
  localparam logic IDLE_SEL_N = 1'h1;
  localparam logic IDLE_UART  = 1'h1;
  localparam logic IDLE_LOW   = 1'h0;

  // Reset values of pad-side and core-side flops.
  localparam logic RST_IRQ_N   = 1'h1;
  localparam logic RST_UART_TX = 1'h1;
  localparam logic RST_LOW     = 1'h0;
  localparam logic [3:0] RST_NIBBLE = 4'h0;

  // Number of shared data pads.
  localparam int DATA_PADS = 4;

  // Control state of the device.
  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_RUN   = 2'b01,
    ST_DOZE  = 2'b10
  } hpm_state_t;

endpackage : hpm_pkg

// [dv/hpm_host_model.sv]
// Purpose: Host side of the pin mux: link clock, strap, wake and pad wires.
// Assumes: A pad that the device does not drive carries the host level.
// Notes:   The link clock stands low between frames.
`timescale 1ns/1ps
module hpm_host_model (
  input  wire logic       link_en,   // Run the link clock.
  input  wire logic       want_spi,  // Mode asked by the bench.
  input  wire logic       want_wake, // Wake asked by the bench.
  input  wire logic [5:0] host_val,  // Host levels on the shared pads.
  input  wire logic [5:0] pad_o,     // Device pad outputs.
  input  wire logic [5:0] pad_oe,    // Device pad drives.
  input  wire logic [1:0] i2c_oe,    // Device open-drain drives, SCL then SDA.
  output logic            link_clk,  // Host bus clock.
  output logic            strap_spi, // Strap level.
  output logic            wake,      // Wake pin.
  output logic [5:0]      pad_i,     // Resolved shared pad levels.
  output logic [1:0]      i2c_i      // Resolved open-drain levels.
);
  // The odd start offset keeps the link clock out of step with CLK.
  initial begin
    link_clk = 1'h0;
    #17;
    forever begin
      wait (link_en);
      // Edges land between CLK edges; the period stays 125 ns.
      #55 link_clk = 1'h1;
      #62.5 link_clk = 1'h0;
      #7.5;
    end
  end
  assign strap_spi = want_spi;
  assign wake = want_wake;
  // Device drive wins; elsewhere the host level stands, so no pad floats.
  assign pad_i = (pad_oe & pad_o) | (~pad_oe & host_val);
  // Internal pull-ups hold a released open-drain line high.
  assign i2c_i = ~i2c_oe;
endmodule : hpm_host_model

// [dv/test_host_port_pin_mux.sv]
// Purpose: Self-checking bench for the host port pin mux.
// Assumes: Inputs change at the falling edge of CLK.
// Notes:   The second bring-up drops hard reset while pads are driven.
`timescale 1ns/1ps
module test_host_port_pin_mux;
  logic        clk, sys_rst, hard_rst_n, want_spi, want_wake, link_en;
  logic        link_clk, strap_spi, wake, doze_req, irq_pending, uart_tx;
  logic        cmd_out, cmd_drv, miso_out, miso_drv, i2c_master, scl_pull, sda_pull;
  logic        core_run, doze_active, wake_event, spi_mode, irq_n;
  logic [3:0]  dat_out, dat_drv;
  logic [5:0]  host_val, pad_i;
  logic [1:0]  i2c_i;
  wire  [5:0]  pad_o, pad_oe;
  wire  [9:0]  routed;
  wire  [1:0]  i2c_oe, i2c_in, i2c_o;
  logic [15:0] lfsr;
  int          error_cnt, cmp_count;

  hpm_host_model u_host (
    .link_en(link_en), .want_spi(want_spi), .want_wake(want_wake), .host_val(host_val),
    .pad_o(pad_o), .pad_oe(pad_oe), .i2c_oe(i2c_oe), .link_clk(link_clk),
    .strap_spi(strap_spi), .wake(wake), .pad_i(pad_i), .i2c_i(i2c_i)
  );

  hpm_top u_dut (
    .CLK(clk), .SYS_RST(sys_rst), .LINK_CLK(link_clk), .HARD_RST_N(hard_rst_n),
    .STRAP_SPI(strap_spi), .HOST_WAKE(wake), .DOZE_REQ(doze_req), .IRQ_PENDING(irq_pending),
    .UART_TX_OUT(uart_tx), .SDIO_CMD_OUT(cmd_out), .SDIO_CMD_DRV(cmd_drv),
    .SDIO_DAT_OUT(dat_out), .SDIO_DAT_DRV(dat_drv), .SPI_MISO_OUT(miso_out),
    .SPI_MISO_DRV(miso_drv), .I2C_MASTER_SEL(i2c_master), .I2C_SCL_PULL(scl_pull),
    .I2C_SDA_PULL(sda_pull), .CORE_RUN(core_run), .DOZE_ACTIVE(doze_active),
    .WAKE_EVENT(wake_event), .SPI_MODE(spi_mode), .HOST_INTERRUPT_LOW(irq_n),
    .SDIO_CLK_IN(routed[9]), .SDIO_CMD_IN(routed[8]), .SDIO_DAT_IN(routed[7:4]),
    .SPI_SCLK_IN(routed[3]), .SPI_MOSI_IN(routed[2]), .SPI_SEL_N_IN(routed[1]),
    .UART_RX_IN(routed[0]), .I2C_SCL_IN(i2c_in[1]), .I2C_SDA_IN(i2c_in[0]),
    .PAD_D3_OR_SERIAL_TX_I(pad_i[5]), .PAD_D3_OR_SERIAL_TX_O(pad_o[5]),
    .PAD_D3_OR_SERIAL_TX_OE(pad_oe[5]), .PAD_D2_OR_MOSI_I(pad_i[4]),
    .PAD_D2_OR_MOSI_O(pad_o[4]), .PAD_D2_OR_MOSI_OE(pad_oe[4]),
    .PAD_D1_OR_SELECT_I(pad_i[3]), .PAD_D1_OR_SELECT_O(pad_o[3]),
    .PAD_D1_OR_SELECT_OE(pad_oe[3]), .PAD_D0_OR_MISO_I(pad_i[2]),
    .PAD_D0_OR_MISO_O(pad_o[2]), .PAD_D0_OR_MISO_OE(pad_oe[2]),
    .PAD_CMD_OR_SCLK_I(pad_i[1]), .PAD_CMD_OR_SCLK_O(pad_o[1]),
    .PAD_CMD_OR_SCLK_OE(pad_oe[1]), .PAD_CLK_OR_SERIAL_RX_I(pad_i[0]),
    .PAD_CLK_OR_SERIAL_RX_O(pad_o[0]), .PAD_CLK_OR_SERIAL_RX_OE(pad_oe[0]),
    .I2C_SCL_I(i2c_i[1]), .I2C_SCL_O(i2c_o[1]), .I2C_SCL_OE(i2c_oe[1]),
    .I2C_SDA_I(i2c_i[0]), .I2C_SDA_O(i2c_o[0]), .I2C_SDA_OE(i2c_oe[0])
  );

  // Expected core-side levels; pad order is d3, d2, d1, d0, cmd, clk.
  function automatic logic [15:0] exp_route(logic spi, logic [5:0] p);
    if (spi) return {12'h000, p[1], p[4], p[3], p[0]};
    return {6'h00, p[0], p[1], p[5:2], 4'h3};
  endfunction : exp_route

  // Expected pad drives; the unused interface never drives.
  function automatic logic [15:0] exp_oe(logic spi);
    if (spi) return {10'h000, 1'h1, 2'h0, miso_drv, 2'h0};
    return {10'h000, dat_drv, cmd_drv, 1'h0};
  endfunction : exp_oe

  function automatic logic [15:0] exp_o(logic spi);
    if (spi) return {10'h000, uart_tx, 2'h0, miso_out, 2'h0};
    return {10'h000, dat_out, cmd_out, 1'h0};
  endfunction : exp_o

  function automatic logic [15:0] lfsr_step(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_step

  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", nm, exp, got);
      error_cnt++;
    end
  endtask : chk

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict

  // A wait that runs out of bound ends the run at once.
  task automatic timeout(string nm);
    $display("mismatch %s expected done seen timeout", nm);
    error_cnt++;
    give_verdict();
  endtask : timeout

  task automatic cycles(int n);
    repeat (n) @(negedge clk);
  endtask : cycles

  // Hard reset with the strap set; repeated, it also hits a running device.
  task automatic bring_up(logic spi);
    hard_rst_n = 1'h0;
    want_spi   = spi;
    cycles(6);
    chk("core_run_held", 16'h0, {15'h0, core_run});
    chk("pad_oe_held", 16'h0, {10'h0, pad_oe});
    hard_rst_n = 1'h1;
    for (int i = 0; i < 12 && core_run !== 1'h1; i++) @(negedge clk);
    if (core_run !== 1'h1) timeout("core_run");
    chk("spi_mode", {15'h0, spi}, {15'h0, spi_mode});
    $display("test bring_up %0d done", spi);
  endtask : bring_up

  // Random pad levels and link drives, four link periods per round.
  task automatic traffic(logic spi);
    for (int k = 0; k < 8; k++) begin
      lfsr = lfsr_step(lfsr);
      {host_val, dat_out, dat_drv} = lfsr[13:0];
      lfsr = lfsr_step(lfsr);
      {cmd_out, cmd_drv, miso_out, miso_drv, uart_tx} = lfsr[4:0];
      link_en = 1'h1;
      cycles(20);
      link_en = 1'h0;
      cycles(8);
      chk("route", exp_route(spi, pad_i), {6'h0, routed});
      chk("pad_oe", exp_oe(spi), {10'h0, pad_oe});
      chk("pad_o", exp_o(spi) & exp_oe(spi), {10'h0, pad_o & pad_oe});
    end
    $display("test traffic %0d done", spi);
  endtask : traffic

  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    #2000000;
    timeout("watchdog");
  end

  initial begin
    {sys_rst, link_en, hard_rst_n, want_spi, want_wake, doze_req, irq_pending} = 7'h61;
    {uart_tx, cmd_out, cmd_drv, miso_out, miso_drv, i2c_master, scl_pull, sda_pull} = 8'h80;
    {dat_out, dat_drv, host_val} = 14'h0000;
    lfsr = 16'h0058;
    error_cnt = 0;
    cmp_count = 0;
    cycles(4);
    sys_rst = 1'h0;
    link_en = 1'h0;
    chk("irq_idle", 16'h1, {15'h0, irq_n});
    irq_pending = 1'h0;
    bring_up(1'h0);
    traffic(1'h0);
    bring_up(1'h1);
    traffic(1'h1);
    // Doze, wake, then a doze request refused while wake stays high.
    doze_req = 1'h1;
    cycles(3);
    chk("doze", 16'h1, {15'h0, doze_active});
    doze_req  = 1'h0;
    want_wake = 1'h1;
    for (int i = 0; i < 8 && doze_active !== 1'h0; i++) @(negedge clk);
    if (doze_active !== 1'h0) timeout("wake");
    chk("wake_event", 16'h1, {15'h0, wake_event});
    cycles(1);
    chk("wake_pulse", 16'h0, {15'h0, wake_event});
    doze_req = 1'h1;
    cycles(3);
    chk("doze_blocked", 16'h0, {15'h0, doze_active});
    {doze_req, want_wake, irq_pending} = 3'h1;
    cycles(1);
    chk("irq_set", 16'h0, {15'h0, irq_n});
    irq_pending = 1'h0;
    cycles(1);
    chk("irq_clear", 16'h1, {15'h0, irq_n});
    $display("test doze_irq done");
    // Test port as slave then master; a slave never drives SCL.
    for (int m = 0; m < 2; m++) begin
      {i2c_master, scl_pull, sda_pull} = {m[0], 2'h3};
      cycles(4);
      chk("i2c_oe", {14'h0, m[0], 1'h1}, {14'h0, i2c_oe});
      chk("i2c_in", {14'h0, ~m[0], 1'h0}, {14'h0, i2c_in});
      chk("i2c_o", 16'h0, {14'h0, i2c_o});
      {scl_pull, sda_pull} = 2'h0;
      cycles(4);
      chk("i2c_release", 16'h0, {14'h0, i2c_oe});
    end
    $display("test i2c done");
    give_verdict();
  end
endmodule : test_host_port_pin_mux
